//--- include/usb_pwr_params.svh
// Constants for the USB port power control block.
`ifndef USB_PWR_PARAMS_SVH
`define USB_PWR_PARAMS_SVH

`define CLK_MHZ 25
`define NUM_PORTS 2
`define TMR_W 26
`define PROBE_W 10
`define UV_W 11

// Times in their own units as printed.
`define T_OC_FILTER_US 5000
`define T_HICCUP_ON_US 5000
`define T_HICCUP_OFF_MS 2000
`define T_UV_FILTER_US 50
`define T_SCP_OFF_US 100
`define T_PROBE_US 20
`define T_SOFTSTART_US 2000

// Cycle counts derived from the clock rate.
`define CYC_OC_FILTER (`T_OC_FILTER_US * `CLK_MHZ)
`define CYC_HICCUP_ON (`T_HICCUP_ON_US * `CLK_MHZ)
`define CYC_HICCUP_OFF (`T_HICCUP_OFF_MS * 1000 * `CLK_MHZ)
`define CYC_UV_FILTER (`T_UV_FILTER_US * `CLK_MHZ)
`define CYC_SCP_OFF (`T_SCP_OFF_US * `CLK_MHZ)
`define CYC_PROBE (`T_PROBE_US * `CLK_MHZ)
`define CYC_SOFTSTART (`T_SOFTSTART_US * `CLK_MHZ)

`endif

//--- include/usb_pwr_pkg.sv
// Types shared by the USB port power control block.
package usb_pwr_pkg;
	typedef enum logic [1:0] {
		CS_PROBE = 2'h0,
		CS_UNATT = 2'h1,
		CS_ATT = 2'h2,
		CS_TYPEA = 2'h3
	} conn_state_t;

	typedef enum logic [2:0] {
		PW_IDLE = 3'h0,
		PW_SOFT = 3'h1,
		PW_ON = 3'h2,
		PW_HIC_OFF = 3'h3,
		PW_HIC_ON = 3'h4,
		PW_SCP_OFF = 3'h5,
		PW_SCP_SOFT = 3'h6
	} pwr_state_t;
endpackage

//--- hdl/sync2.sv
// Two-flop synchroniser bank for asynchronous inputs.
`timescale 1ns/10ps
`default_nettype none
module sync2 #(
	parameter int unsigned W = 1
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] meta;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			meta <= '0;
			dout <= '0;
		end else begin
			meta <= din;
			dout <= meta;
		end
	end
endmodule // sync2
`default_nettype wire

//--- hdl/usb_port_power_control.sv
// Attach, probe, fault timing and discharge control for two USB ports.
`timescale 1ns/10ps
`default_nettype none
`include "usb_pwr_params.svh"
module usb_port_power_control #(
	parameter int unsigned OC_FILTER_CYCLES = `CYC_OC_FILTER,
	parameter int unsigned HICCUP_ON_CYCLES = `CYC_HICCUP_ON,
	parameter int unsigned HICCUP_OFF_CYCLES = `CYC_HICCUP_OFF,
	parameter int unsigned SOFTSTART_CYCLES = `CYC_SOFTSTART
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic enable_pin,
	input wire logic vin_above_uvlo,
	input wire logic die_above_165c,
	input wire logic die_below_145c,
	input wire logic [1:0] port_current_limit,
	input wire logic [1:0] port_vout_low,
	input wire logic [1:0] port_secondary_limit,
	input wire logic [1:0] port_vout_dead,
	input wire logic [1:0] cc_primary_rd,
	input wire logic [1:0] cc_primary_ra,
	input wire logic [1:0] cc_secondary_rd,
	input wire logic [1:0] cc_secondary_ra,
	input wire logic [1:0] probe_in_window,
	input wire logic isense_port2_larger,
	output logic port1_vbus_out,
	output logic port2_vbus_out,
	output logic [1:0] vconn_primary_en,
	output logic [1:0] vconn_secondary_en,
	output logic [1:0] discharge_en,
	output logic [1:0] probe_source_en,
	output logic [1:0] type_a_limit,
	output logic [1:0] cc_pullup_3a_en,
	output logic regulator_en,
	output logic ldc_use_port2
);
	import usb_pwr_pkg::*;

	localparam int unsigned NP = `NUM_PORTS;
	localparam int unsigned SW = 5 + 9 * NP;

	logic [SW-1:0] raw_in;
	logic [SW-1:0] sync_in;
	logic en_s;
	logic uvlo_ok_s;
	logic hot_s;
	logic cool_s;
	logic isense2_s;
	logic [1:0] cl_s;
	logic [1:0] vlow_s;
	logic [1:0] sec_s;
	logic [1:0] vdead_s;
	logic [1:0] prd_s;
	logic [1:0] pra_s;
	logic [1:0] srd_s;
	logic [1:0] sra_s;
	logic [1:0] pwin_s;
	logic part_on;
	logic over_temp;
	logic next_over_temp;
	conn_state_t conn [NP];
	conn_state_t next_conn [NP];
	pwr_state_t pwr [NP];
	pwr_state_t next_pwr [NP];
	logic [`TMR_W-1:0] tmr [NP];
	logic [`TMR_W-1:0] next_tmr [NP];
	logic [`UV_W-1:0] uvc [NP];
	logic [`UV_W-1:0] next_uvc [NP];
	logic [`PROBE_W-1:0] pcnt [NP];
	logic [`PROBE_W-1:0] next_pcnt [NP];
	logic [1:0] next_vbus;
	logic [1:0] next_vconn_pri;
	logic [1:0] next_vconn_sec;
	logic [1:0] next_discharge;
	logic [1:0] next_probe_src;
	logic [1:0] next_type_a;
	logic [1:0] next_pullup;
	logic next_regulator;
	logic next_ldc;
	logic [1:0] vbus_want;
	logic [1:0] vbus_q;

	// True on the last cycle of a timed interval of lim cycles.
	function automatic logic expired(input logic [`TMR_W-1:0] c,
		input int unsigned lim);
		expired = (c >= `TMR_W'(lim - 1));
	endfunction

	// Valid sink: Rd on exactly one line; Rd/Rd is a debug accessory.
	function automatic logic sink_seen(input logic rd_a, input logic rd_b);
		sink_seen = rd_a ^ rd_b;
	endfunction

	assign raw_in = {enable_pin, vin_above_uvlo, die_above_165c,
		die_below_145c, isense_port2_larger, port_current_limit,
		port_vout_low, port_secondary_limit, port_vout_dead, cc_primary_rd,
		cc_primary_ra, cc_secondary_rd, cc_secondary_ra, probe_in_window};

	sync2 #(
		.W(SW)
	) u_sync (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.din(raw_in),
		.dout(sync_in)
	);

	assign {en_s, uvlo_ok_s, hot_s, cool_s, isense2_s, cl_s, vlow_s, sec_s,
		vdead_s, prd_s, pra_s, srd_s, sra_s, pwin_s} = sync_in;

	assign part_on = en_s & uvlo_ok_s;

	always_comb begin
		next_over_temp = over_temp;
		if (hot_s) begin
			next_over_temp = 1'b1;
		end else if (cool_s) begin
			next_over_temp = 1'b0;
		end
	end

	always_comb begin
		for (int p = 0; p < NP; p++) begin
			next_conn[p] = conn[p];
			next_pcnt[p] = pcnt[p];
			if (!part_on) begin
				next_conn[p] = CS_PROBE;
				next_pcnt[p] = '0;
			end else begin
				case (conn[p])
					CS_PROBE: begin
						next_pcnt[p] = pcnt[p] + `PROBE_W'(1);
						if (pcnt[p] == `PROBE_W'(`CYC_PROBE)) begin
							next_conn[p] = pwin_s[p] ? CS_TYPEA : CS_UNATT;
						end
					end
					CS_UNATT: begin
						if (sink_seen(prd_s[p], srd_s[p])) begin
							next_conn[p] = CS_ATT;
						end
					end
					CS_ATT: begin
						if (!sink_seen(prd_s[p], srd_s[p])) begin
							next_conn[p] = CS_UNATT;
						end
					end
					CS_TYPEA: begin
						next_conn[p] = CS_TYPEA;
					end
					default: begin
						next_conn[p] = CS_PROBE;
					end
				endcase
			end
		end
	end

	always_comb begin
		for (int p = 0; p < NP; p++) begin
			vbus_want[p] = part_on & ~over_temp &
				((next_conn[p] == CS_ATT) | (next_conn[p] == CS_TYPEA));
		end
	end

	always_comb begin
		for (int p = 0; p < NP; p++) begin
			next_pwr[p] = pwr[p];
			next_tmr[p] = tmr[p] + `TMR_W'(1);
			next_uvc[p] = '0;
			if (!vbus_want[p]) begin
				next_pwr[p] = PW_IDLE;
				next_tmr[p] = '0;
			end else begin
				case (pwr[p])
					PW_IDLE: begin
						next_pwr[p] = PW_SOFT;
						next_tmr[p] = '0;
					end
					PW_SOFT: begin
						if (sec_s[p]) begin
							next_pwr[p] = PW_SCP_OFF;
							next_tmr[p] = '0;
						end else if (expired(tmr[p], SOFTSTART_CYCLES)) begin
							next_pwr[p] = PW_ON;
							next_tmr[p] = '0;
						end
					end
					PW_ON: begin
						next_tmr[p] = cl_s[p] ? tmr[p] + `TMR_W'(1) : '0;
						next_uvc[p] = vlow_s[p] ? uvc[p] + `UV_W'(1) : '0;
						if (sec_s[p]) begin
							next_pwr[p] = PW_SCP_OFF;
							next_tmr[p] = '0;
						end else if (vlow_s[p] &&
							uvc[p] == `UV_W'(`CYC_UV_FILTER - 1)) begin
							next_pwr[p] = PW_HIC_OFF;
							next_tmr[p] = '0;
						end else if (cl_s[p] &&
							expired(tmr[p], OC_FILTER_CYCLES)) begin
							next_pwr[p] = PW_HIC_OFF;
							next_tmr[p] = '0;
						end
					end
					PW_HIC_OFF: begin
						if (expired(tmr[p], HICCUP_OFF_CYCLES)) begin
							next_pwr[p] = PW_HIC_ON;
							next_tmr[p] = '0;
						end
					end
					PW_HIC_ON: begin
						if (sec_s[p]) begin
							next_pwr[p] = PW_SCP_OFF;
							next_tmr[p] = '0;
						end else if (expired(tmr[p], HICCUP_ON_CYCLES)) begin
							next_pwr[p] = (cl_s[p] | vlow_s[p]) ?
								PW_HIC_OFF : PW_ON;
							next_tmr[p] = '0;
						end
					end
					PW_SCP_OFF: begin
						if (expired(tmr[p], `CYC_SCP_OFF)) begin
							next_pwr[p] = PW_SCP_SOFT;
							next_tmr[p] = '0;
						end
					end
					PW_SCP_SOFT: begin
						if (expired(tmr[p], SOFTSTART_CYCLES)) begin
							next_pwr[p] = PW_ON;
							next_tmr[p] = '0;
						end
					end
					default: begin
						next_pwr[p] = PW_IDLE;
						next_tmr[p] = '0;
					end
				endcase
			end
		end
	end

	// Registered outputs, computed from the next state, except ldc_use_port2, which follows isense2_s, and discharge_en, which compares vbus_q with vbus_want.
	always_comb begin
		for (int p = 0; p < NP; p++) begin
			next_vbus[p] = (next_pwr[p] == PW_SOFT) ||
				(next_pwr[p] == PW_ON) || (next_pwr[p] == PW_HIC_ON) ||
				(next_pwr[p] == PW_SCP_SOFT);
			next_vconn_pri[p] = vbus_want[p] &&
				(next_conn[p] == CS_ATT) && pra_s[p] && srd_s[p];
			next_vconn_sec[p] = vbus_want[p] &&
				(next_conn[p] == CS_ATT) && sra_s[p] && prd_s[p];
			if ((vbus_q[p] && !vbus_want[p]) || (!part_on && !vdead_s[p])) begin
				next_discharge[p] = 1'b1;
			end else if (vdead_s[p]) begin
				next_discharge[p] = 1'b0;
			end else begin
				next_discharge[p] = discharge_en[p];
			end
			next_probe_src[p] = (next_conn[p] == CS_PROBE) && part_on;
			next_type_a[p] = (next_conn[p] == CS_TYPEA);
			next_pullup[p] = part_on && (next_conn[p] != CS_PROBE) &&
				(next_conn[p] != CS_TYPEA);
		end
		next_regulator = part_on & ~next_over_temp;
		next_ldc = isense2_s;
	end

	assign vbus_q = {port2_vbus_out, port1_vbus_out};

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			over_temp <= 1'b0;
			for (int p = 0; p < NP; p++) begin
				conn[p] <= CS_PROBE;
				pwr[p] <= PW_IDLE;
				tmr[p] <= '0;
				uvc[p] <= '0;
				pcnt[p] <= '0;
			end
			port1_vbus_out <= 1'b0;
			port2_vbus_out <= 1'b0;
			vconn_primary_en <= 2'h0;
			vconn_secondary_en <= 2'h0;
			discharge_en <= 2'h0;
			probe_source_en <= 2'h0;
			type_a_limit <= 2'h0;
			cc_pullup_3a_en <= 2'h0;
			regulator_en <= 1'b0;
			ldc_use_port2 <= 1'b0;
		end else begin
			over_temp <= next_over_temp;
			for (int p = 0; p < NP; p++) begin
				conn[p] <= next_conn[p];
				pwr[p] <= next_pwr[p];
				tmr[p] <= next_tmr[p];
				uvc[p] <= next_uvc[p];
				pcnt[p] <= next_pcnt[p];
			end
			port1_vbus_out <= next_vbus[0];
			port2_vbus_out <= next_vbus[1];
			vconn_primary_en <= next_vconn_pri;
			vconn_secondary_en <= next_vconn_sec;
			discharge_en <= next_discharge;
			probe_source_en <= next_probe_src;
			type_a_limit <= next_type_a;
			cc_pullup_3a_en <= next_pullup;
			regulator_en <= next_regulator;
			ldc_use_port2 <= next_ldc;
		end
	end
endmodule // usb_port_power_control
`default_nettype wire

//--- sim/usb_port_power_control_assertions.sv
// Port-level assertions for the USB port power control block.
`timescale 1ns/10ps
`default_nettype none
module usb_pwr_checker (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic enable_pin,
	input wire logic die_above_165c,
	input wire logic [1:0] cc_primary_rd,
	input wire logic [1:0] cc_secondary_rd,
	input wire logic [1:0] cc_secondary_ra,
	input wire logic [1:0] port_vout_dead,
	input wire logic port1_vbus_out,
	input wire logic port2_vbus_out,
	input wire logic [1:0] vconn_primary_en,
	input wire logic [1:0] vconn_secondary_en,
	input wire logic [1:0] discharge_en,
	input wire logic [1:0] probe_source_en,
	input wire logic [1:0] type_a_limit,
	input wire logic regulator_en
);
	int pcnt;
	int next_pcnt;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	// Counts how long the port 1 probe source has been on.
	always_comb begin
		next_pcnt = probe_source_en[0] ? pcnt + 1 : 0;
	end
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			pcnt <= 0;
		end else begin
			pcnt <= next_pcnt;
		end
	end
	a_enable_off: assert property (!enable_pin [*5] |-> !regulator_en
		&& !port1_vbus_out && !port2_vbus_out) else $error("on while off");
	a_overtemp_off: assert property (die_above_165c [*5] |->
		!regulator_en && !port1_vbus_out) else $error("on while hot");
	a_probe_quiet: assert property (probe_source_en[0] |->
		!port1_vbus_out) else $error("vbus on during probe");
	a_probe_length: assert property ($fell(probe_source_en[0])
		&& enable_pin |-> pcnt == 500) else $error("probe length");
	a_vconn_on_ra: assert property ($rose(vconn_secondary_en[0]) |->
		$past(cc_secondary_ra[0], 3)) else $error("vconn without ra");
	a_vconn_one_line: assert property (!(vconn_primary_en[0]
		&& vconn_secondary_en[0])) else $error("vconn on both lines");
	a_detach_off: assert property ($fell(cc_primary_rd[0])
		&& !cc_secondary_rd[0] && !type_a_limit[0] |-> ##[1:4]
		(!port1_vbus_out && !vconn_secondary_en[0])) else $error("detach");
	a_discharge_set: assert property ($fell(cc_primary_rd[0])
		&& port1_vbus_out && !cc_secondary_rd[0] && !type_a_limit[0]
		|-> ##[1:4] discharge_en[0]) else $error("no discharge");
	a_discharge_end: assert property (port_vout_dead[0] [*5] |->
		!discharge_en[0]) else $error("discharge stuck");
	a_type_a_on: assert property ($rose(type_a_limit[1]) |->
		##[0:2] port2_vbus_out) else $error("type-a vbus off");
	c_attach: cover property ($rose(port1_vbus_out));
	c_type_a: cover property ($rose(type_a_limit[1]));
	c_discharge: cover property ($rose(discharge_en[0]));
endmodule // usb_pwr_checker

bind usb_port_power_control usb_pwr_checker u_chk (.sys_clk, .rst_b,
	.enable_pin, .die_above_165c, .cc_primary_rd, .cc_secondary_rd,
	.cc_secondary_ra, .port_vout_dead, .port1_vbus_out, .port2_vbus_out,
	.vconn_primary_en, .vconn_secondary_en, .discharge_en, .probe_source_en,
	.type_a_limit, .regulator_en);
`default_nettype wire

//--- sim/usb_sink_model.sv
// Behavioural sink, powered cable or Type-A board on one port.
`timescale 1ns/10ps
`default_nettype none
module usb_sink_model (
	input wire logic sys_clk,
	input wire logic [1:0] mode,
	input wire logic type_a_board,
	input wire logic flip,
	input wire logic vbus,
	input wire logic discharge,
	input wire logic probe,
	output logic rd_p,
	output logic ra_p,
	output logic rd_s,
	output logic ra_s,
	output logic dead,
	output logic in_window
);
	int level = 0;
	logic rd_1;
	logic ra_1;
	logic rd_2;
	logic ra_2;
	// Mode 0 open, 1 sink behind a powered cable, 2 Ra/Ra, 3 Rd/Rd.
	assign rd_1 = !type_a_board && mode inside {2'h1, 2'h3};
	assign ra_1 = !type_a_board && mode == 2'h2;
	assign rd_2 = !type_a_board && mode == 2'h3;
	assign ra_2 = !type_a_board && mode inside {2'h1, 2'h2};
	// A flipped plug swaps the two CC lines.
	assign rd_p = flip ? rd_2 : rd_1;
	assign ra_p = flip ? ra_2 : ra_1;
	assign rd_s = flip ? rd_1 : rd_2;
	assign ra_s = flip ? ra_1 : ra_2;
	assign in_window = type_a_board && probe;
	assign dead = level == 0;
	// The output only drains while the fast discharge path is on.
	always @(negedge sys_clk) begin
		if (vbus) begin
			level <= 6;
		end else if (discharge && level > 0) begin
			level <= level - 1;
		end
	end
endmodule // usb_sink_model
`default_nettype wire

//--- sim/test_usb_port_power_control.sv
// Self-checking bench for the USB port power control block.
`timescale 1ns/10ps
`default_nettype none
module test_usb_port_power_control;
	logic sys_clk = 1'h0;
	logic rst_b = 1'h0;
	logic enable_pin = 1'h1;
	logic vin_above_uvlo = 1'h1;
	logic die_above_165c = 1'h0;
	logic die_below_145c = 1'h1;
	logic [1:0] port_current_limit = 2'h0;
	logic [1:0] port_vout_low = 2'h0;
	logic [1:0] port_secondary_limit = 2'h0;
	logic isense_port2_larger = 1'h0;
	logic [1:0] mode1 = 2'h0;
	logic [1:0] mode2 = 2'h0;
	logic type_a1 = 1'h0;
	logic type_a2 = 1'h1;
	logic flip2 = 1'h0;
	wire logic [1:0] rdp, rap, rds, ras, dead, win;
	logic port1_vbus_out, port2_vbus_out, regulator_en, ldc_use_port2;
	logic [1:0] vconn_primary_en, vconn_secondary_en, discharge_en;
	logic [1:0] probe_source_en, type_a_limit, cc_pullup_3a_en;
	wire logic [1:0] vbus = {port2_vbus_out, port1_vbus_out};
	int errors = 0;
	int cmp_count = 0;
	usb_port_power_control #(.OC_FILTER_CYCLES(20), .HICCUP_ON_CYCLES(20),
		.HICCUP_OFF_CYCLES(40), .SOFTSTART_CYCLES(10)) dut (.sys_clk, .rst_b,
		.enable_pin, .vin_above_uvlo, .die_above_165c, .die_below_145c,
		.port_current_limit, .port_vout_low, .port_secondary_limit,
		.port_vout_dead(dead), .cc_primary_rd(rdp), .cc_primary_ra(rap),
		.cc_secondary_rd(rds), .cc_secondary_ra(ras), .probe_in_window(win),
		.isense_port2_larger, .port1_vbus_out, .port2_vbus_out,
		.vconn_primary_en, .vconn_secondary_en, .discharge_en,
		.probe_source_en, .type_a_limit, .cc_pullup_3a_en, .regulator_en,
		.ldc_use_port2);
	usb_sink_model sink1 (.sys_clk, .mode(mode1), .type_a_board(type_a1),
		.flip(1'h0), .vbus(port1_vbus_out), .discharge(discharge_en[0]),
		.probe(probe_source_en[0]), .rd_p(rdp[0]), .ra_p(rap[0]),
		.rd_s(rds[0]), .ra_s(ras[0]), .dead(dead[0]), .in_window(win[0]));
	// Port 2 carries a Type-A board to exercise its own probe.
	usb_sink_model sink2 (.sys_clk, .mode(mode2), .type_a_board(type_a2),
		.flip(flip2), .vbus(port2_vbus_out), .discharge(discharge_en[1]),
		.probe(probe_source_en[1]), .rd_p(rdp[1]), .ra_p(rap[1]),
		.rd_s(rds[1]), .ra_s(ras[1]), .dead(dead[1]), .in_window(win[1]));
	initial begin
		forever #20 sys_clk = ~sys_clk;
	end
	task automatic w(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic check(input logic [1:0] seen, input logic [1:0] exp,
		input string what);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic end_of_test;
		$display("errors %0d comparisons %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic t_probe;
		w(515);
		check(type_a_limit, 2'h2, "type_a");
		check(cc_pullup_3a_en, 2'h1, "pullup");
		check(2'(ldc_use_port2), 2'h0, "ldc");
		w(3);
		check(vbus, 2'h2, "vbus");
	endtask
	task automatic t_attach;
		mode1 = 2'h1;
		isense_port2_larger = 1'h1;
		w(4);
		check(vbus, 2'h3, "vbus");
		check(vconn_secondary_en, 2'h1, "vconn_s");
		check(vconn_primary_en, 2'h0, "vconn_p");
		check(2'(ldc_use_port2), 2'h1, "ldc");
		mode1 = 2'h0;
		w(4);
		check(vbus, 2'h2, "vbus");
		check(vconn_secondary_en, 2'h0, "vconn_s");
		check(discharge_en, 2'h1, "discharge");
		w(12);
		check(discharge_en, 2'h0, "discharge");
	endtask
	task automatic t_accessory;
		for (int m = 2; m < 4; m++) begin
			mode1 = 2'(m);
			w(6);
			check(vbus, 2'h2, "vbus");
			check(vconn_secondary_en, 2'h0, "vconn_s");
			mode1 = 2'h0;
			w(2);
		end
	endtask
	task automatic t_fault;
		mode1 = 2'h1;
		w(20);
		port_current_limit = 2'h1;
		w(30);
		check(vbus, 2'h2, "vbus");
		port_current_limit = 2'h0;
		w(50);
		check(vbus, 2'h3, "vbus");
		w(30);
		port_vout_low = 2'h1;
		w(1240);
		check(vbus, 2'h3, "vbus");
		w(20);
		check(vbus, 2'h2, "vbus");
		port_vout_low = 2'h0;
		w(100);
	endtask
	task automatic t_short;
		port_secondary_limit = 2'h1;
		w(5);
		check(vbus, 2'h2, "vbus");
		w(2390);
		check(vbus, 2'h2, "vbus");
		w(113);
		check(vbus, 2'h3, "vbus");
		port_secondary_limit = 2'h0;
		w(10);
		check(vbus, 2'h3, "vbus");
	endtask
	task automatic t_thermal;
		die_above_165c = 1'h1;
		die_below_145c = 1'h0;
		w(5);
		check(vbus, 2'h0, "vbus");
		check(2'(regulator_en), 2'h0, "reg");
		die_above_165c = 1'h0;
		w(5);
		check(vbus, 2'h0, "vbus");
		die_below_145c = 1'h1;
		w(5);
		check(2'(regulator_en), 2'h1, "reg");
		check(vbus, 2'h3, "vbus");
	endtask
	task automatic t_enable;
		enable_pin = 1'h0;
		w(5);
		check(2'(regulator_en), 2'h0, "reg");
		check(vbus, 2'h0, "vbus");
		check(discharge_en, 2'h3, "discharge");
		w(12);
		check(discharge_en, 2'h0, "discharge");
		enable_pin = 1'h1;
		vin_above_uvlo = 1'h0;
		type_a1 = 1'h1;
		type_a2 = 1'h0;
		mode2 = 2'h1;
		flip2 = 1'h1;
		w(5);
		check(probe_source_en, 2'h0, "probe");
		vin_above_uvlo = 1'h1;
		w(515);
		check(type_a_limit, 2'h1, "type_a");
		check(vbus, 2'h3, "vbus");
		check(cc_pullup_3a_en, 2'h2, "pullup");
		check(vconn_primary_en, 2'h2, "vconn_p");
		check(vconn_secondary_en, 2'h0, "vconn_s");
	endtask
	initial begin
		w(8);
		rst_b = 1'h1;
		w(1);
		check(vbus, 2'h0, "vbus");
		t_probe;
		t_attach;
		t_accessory;
		t_fault;
		t_short;
		t_thermal;
		t_enable;
		end_of_test;
	end
	initial begin
		repeat (12000) @(posedge sys_clk);
		errors++;
		end_of_test;
	end
endmodule // test_usb_port_power_control
`default_nettype wire
